// file: design/dpc_host.v
/*
  Host controller for one port of an asynchronous dual-port static memory:
  array writes, array reads, semaphore take and release with read-back.
  Assumes the device pins sit on this clock domain and the bench resolves
  the data wire from data_pins_oe.
*/
// Contract
// - Host selects array or flag, never both, held through write window.
// - Write strobe or array select high whenever address changes.
// - Host drives write data only after device outputs are off.
// - With output enable low, write pulse covers turn-off plus data setup.
// - Host holds write data after end of every write.
// - Array select stays high across semaphore write and read.
`timescale 1ns/1ps
`include "dpc_map.vh"
module dpc_host (
  input  wire                clk,
  input  wire                reset_n,
  input  wire                req,
  input  wire [1:0]          req_cmd,
  input  wire [`DPC_AW-1:0]  req_addr,
  input  wire [`DPC_DW-1:0]  req_wdata,
  output reg                 busy,
  output reg                 done,
  output reg  [`DPC_DW-1:0]  rdata,
  output reg                 flag_won,
  output reg                 array_select_n,
  output reg                 flag_select_n,
  output reg                 write_n,
  output reg                 output_enable_n,
  output reg  [`DPC_AW-1:0]  addr,
  input  wire [`DPC_DW-1:0]  data_pins_in,
  output reg  [`DPC_DW-1:0]  data_pins_out,
  output reg                 data_pins_oe
);
  // ---------------------------------------------------------------------------
  // Phase lengths in cycles
  // ---------------------------------------------------------------------------
  function [3:0] cyc_up;
    input integer ns;
    integer c;
    begin
      c = (ns * 1000 + `DPC_CLK_PS - 1) / `DPC_CLK_PS;
      if (c < 1)
        c = 1;
      cyc_up = c[3:0];
    end
  endfunction

  function [3:0] max4;
    input [3:0] a;
    input [3:0] b;
    begin
      max4 = (a > b) ? a : b;
    end
  endfunction

  localparam [3:0] WP_CYC   = max4(cyc_up(`DPC_T_WP_NS), cyc_up(`DPC_T_DW_NS));
  localparam [3:0] HZ_CYC   = max4(cyc_up(`DPC_T_HZ_NS), cyc_up(`DPC_T_WZ_NS));
  localparam [3:0] SWRD_CYC = cyc_up(`DPC_T_SWRD_NS);
  localparam [3:0] SAA_CYC  = cyc_up(`DPC_T_SAA_NS);
  localparam [3:0] WR_CYC   = max4(cyc_up(`DPC_T_WR_NS), cyc_up(`DPC_T_DH_NS));

  // ---------------------------------------------------------------------------
  // States
  // ---------------------------------------------------------------------------
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_SETUP = 8'h02;
  localparam [7:0] S_WPULS = 8'h04;
  localparam [7:0] S_WHOLD = 8'h08;
  localparam [7:0] S_WGAP  = 8'h10;
  localparam [7:0] S_RACC  = 8'h20;
  localparam [7:0] S_TURN  = 8'h40;

  reg [7:0]         state;
  reg [1:0]         cmd;
  reg [`DPC_DW-1:0] wdata;
  reg               t_load;
  reg [3:0]         t_val;
  wire              t_expired;

  wire is_flag  = cmd[1];
  wire is_write = (cmd != `DPC_CMD_READ);

  dpc_timer u_timer (
    .clk      (clk),
    .reset_n  (reset_n),
    .load     (t_load),
    .load_val (t_val),
    .expired  (t_expired)
  );

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state           <= S_IDLE;
      cmd             <= 2'h0;
      wdata           <= 8'h00;
      t_load          <= 1'b0;
      t_val           <= 4'h1;
      busy            <= 1'b0;
      done            <= 1'b0;
      rdata           <= 8'h00;
      flag_won        <= 1'b0;
      array_select_n  <= 1'b1;
      flag_select_n   <= 1'b1;
      write_n         <= 1'b1;
      output_enable_n <= 1'b1;
      addr            <= 13'h0000;
      data_pins_out   <= 8'h00;
      data_pins_oe    <= 1'b0;
    end
    else
    begin
      t_load <= 1'b0;
      done   <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (req)
          begin
            busy  <= 1'b1;
            cmd   <= req_cmd;
            addr  <= req_addr;
            if (req_cmd == `DPC_CMD_TAKE)
              wdata <= 8'hfe;
            else if (req_cmd == `DPC_CMD_GIVE)
              wdata <= 8'hff;
            else
              wdata <= req_wdata;
            array_select_n <= req_cmd[1];
            flag_select_n  <= ~req_cmd[1];
            state          <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          t_load <= 1'b1;
          if (is_write)
          begin
            // Output enable stays high, so the device is already off
            write_n       <= 1'b0;
            data_pins_oe  <= 1'b1;
            data_pins_out <= wdata;
            t_val         <= WP_CYC;
            state         <= S_WPULS;
          end
          else
          begin
            output_enable_n <= 1'b0;
            t_val           <= SAA_CYC;
            state           <= S_RACC;
          end
        end
        S_WPULS:
        begin
          if (t_expired && !t_load)
          begin
            write_n <= 1'b1;
            t_load  <= 1'b1;
            t_val   <= WR_CYC;
            state   <= S_WHOLD;
          end
        end
        S_WHOLD:
        begin
          if (t_expired && !t_load)
          begin
            data_pins_oe <= 1'b0;
            t_load       <= 1'b1;
            if (is_flag)
            begin
              t_val <= SWRD_CYC;
              state <= S_WGAP;
            end
            else
            begin
              array_select_n <= 1'b1;
              t_val          <= WR_CYC;
              state          <= S_TURN;
            end
          end
        end
        S_WGAP:
        begin
          // Array select untouched: stays high into the read-back
          if (t_expired && !t_load)
          begin
            output_enable_n <= 1'b0;
            t_load          <= 1'b1;
            t_val           <= SAA_CYC;
            state           <= S_RACC;
          end
        end
        S_RACC:
        begin
          if (t_expired && !t_load)
          begin
            rdata <= data_pins_in;
            if (cmd == `DPC_CMD_TAKE)
              flag_won <= ~data_pins_in[0];
            else if (cmd == `DPC_CMD_GIVE)
              flag_won <= 1'b0;
            output_enable_n <= 1'b1;
            array_select_n  <= 1'b1;
            flag_select_n   <= 1'b1;
            t_load          <= 1'b1;
            t_val           <= HZ_CYC;
            state           <= S_TURN;
          end
        end
        S_TURN:
        begin
          flag_select_n <= 1'b1;
          if (t_expired && !t_load)
          begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= S_IDLE;
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// file: design/dpc_map.vh
/*
  Constants for the dual-port memory port host: pin timing in ns, command codes,
  widths. Assumes a single 250 MHz clock.
*/
`ifndef DPC_MAP_VH
`define DPC_MAP_VH

// ---------------------------------------------------------------------------
// Clock
// ---------------------------------------------------------------------------
`define DPC_CLK_PS      4000

// ---------------------------------------------------------------------------
// Pin timing, ns
// ---------------------------------------------------------------------------
`define DPC_T_WP_NS     12
`define DPC_T_DW_NS     10
`define DPC_T_WZ_NS     10
`define DPC_T_HZ_NS     10
`define DPC_T_SWRD_NS   5
`define DPC_T_SAA_NS    15
`define DPC_T_DH_NS     0
`define DPC_T_WR_NS     0

// ---------------------------------------------------------------------------
// Commands and widths
// ---------------------------------------------------------------------------
`define DPC_CMD_WRITE   2'h0
`define DPC_CMD_READ    2'h1
`define DPC_CMD_TAKE    2'h2
`define DPC_CMD_GIVE    2'h3
`define DPC_AW          13
`define DPC_DW          8

`endif

// file: design/dpc_timer.v
/*
  Down counter for pin phase lengths.
  Assumes load_val of at least one; expired rises load_val cycles after load.
*/
`timescale 1ns/1ps
module dpc_timer (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       load,
  input  wire [3:0] load_val,
  output wire       expired
);
  reg [3:0] count;

  always @(posedge clk)
  begin
    if (!reset_n)
      count <= 4'h0;
    else if (load)
      count <= load_val;
    else if (count != 4'h0)
      count <= count - 4'h1;
  end

  assign expired = (count == 4'h0);
endmodule

// file: verification/dpc_host_monitor.sv
/* Pin checker for the dual-port memory port host.
   Bound to dpc_host; sees only its ports. */
`timescale 1ns/1ps
`include "dpc_map.vh"
module dpc_host_monitor (
  input wire               clk,
  input wire               reset_n,
  input wire               array_select_n,
  input wire               flag_select_n,
  input wire               write_n,
  input wire               output_enable_n,
  input wire [`DPC_AW-1:0] addr,
  input wire [`DPC_DW-1:0] data_pins_out,
  input wire               data_pins_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Checks
  // ----
  property p_sel_hold; !write_n |=> $stable(array_select_n) && $stable(flag_select_n); endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed in write");
  property p_sel_excl; !flag_select_n |-> array_select_n; endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("array and flag selected");
  property p_addr_move; !$stable(addr) |-> write_n || array_select_n; endproperty
  a_addr_move: assert property (p_addr_move) else $error("address moved in write");
  property p_no_clash; data_pins_oe |-> output_enable_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("data driven with outputs on");
  property p_oe_off; !write_n |-> output_enable_n; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enable low in write");
  property p_pulse; $fell(write_n) |-> (!write_n)[*5] ##1 write_n; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
  property p_hold; $rose(write_n) |-> data_pins_oe && $stable(data_pins_out); endproperty
  a_hold: assert property (p_hold) else $error("write data not held");
endmodule
bind dpc_host dpc_host_monitor u_mon (
  .clk(clk), .reset_n(reset_n), .array_select_n(array_select_n),
  .flag_select_n(flag_select_n), .write_n(write_n), .output_enable_n(output_enable_n),
  .addr(addr), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));

// file: verification/dpc_dev_model.sv
/* Model of one port of the dual-port memory; the opposite port is cut down
   to flag take and give strobes. Assumes pins are synchronous to clk. */
`timescale 1ns/1ps
module dpc_dev_model (
  input  wire        clk,
  input  wire        sel_n,
  input  wire        flag_n,
  input  wire        wr_n,
  input  wire        oe_n,
  input  wire [12:0] addr,
  input  wire [7:0]  host_d,
  input  wire        host_oe,
  input  wire        other_take,
  input  wire        other_give,
  input  wire [2:0]  other_flag,
  output wire [7:0]  bus
);
  reg  [7:0]  mem [0:8191];
  reg  [1:0]  own [0:7];
  reg  [7:0]  last = 8'h00;
  reg  [7:0]  wd = 8'h00;
  reg  [12:0] wa = 13'h0000;
  reg         wf = 1'b0;
  reg         act = 1'b0;
  integer     i;
  wire        wr_lo = !wr_n && !(sel_n && flag_n);
  wire        drv = !oe_n && wr_n && !(sel_n && flag_n);
  wire [7:0]  q = !flag_n ? {8{own[addr[2:0]] != 2'h1}} : mem[addr];
  // Undriven pins toggle every cycle
  assign bus = host_oe ? host_d : drv ? q : ~last;
  initial for (i = 0; i < 8; i = i + 1) own[i] = 2'h0;
  always @(posedge clk)
  begin
    last <= bus;
    act <= wr_lo;
    if (wr_lo)
    begin
      wa <= addr;
      wd <= bus;
      wf <= !flag_n;
    end
    if (act && !wr_lo && !wf) mem[wa] <= wd;
    if (act && !wr_lo && wf && !wd[0] && own[wa[2:0]] == 2'h0) own[wa[2:0]] <= 2'h1;
    if (act && !wr_lo && wf && wd[0] && own[wa[2:0]] == 2'h1) own[wa[2:0]] <= 2'h0;
    // Same-edge requests: the later assignment leaves exactly one owner
    if (other_take && own[other_flag] == 2'h0) own[other_flag] <= 2'h2;
    if (other_give && own[other_flag] == 2'h2) own[other_flag] <= 2'h0;
  end
endmodule

// file: verification/testbench.sv
/* Self-checking bench: dpc_host against the device model.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
`include "dpc_map.vh"
module testbench;
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         req = 1'b0;
  reg  [1:0]  req_cmd = 2'h0;
  reg  [12:0] req_addr = 13'h0000;
  reg  [7:0]  req_wdata = 8'h00;
  reg         other_take = 1'b0;
  reg         other_give = 1'b0;
  reg  [2:0]  other_flag = 3'h0;
  wire        busy, done, flag_won, sel_n, flag_n, wr_n, oe_n, d_oe;
  wire [7:0]  rdata, d_out, bus;
  wire [12:0] addr;
  integer     miscompares = 0;
  integer     n_compared = 0;
  dpc_host DUT (.clk(clk), .reset_n(reset_n), .req(req), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata), .flag_won(flag_won),
    .array_select_n(sel_n), .flag_select_n(flag_n), .write_n(wr_n), .output_enable_n(oe_n),
    .addr(addr), .data_pins_in(bus), .data_pins_out(d_out), .data_pins_oe(d_oe));
  dpc_dev_model u_dev (.clk(clk), .sel_n(sel_n), .flag_n(flag_n), .wr_n(wr_n), .oe_n(oe_n),
    .addr(addr), .host_d(d_out), .host_oe(d_oe), .other_take(other_take),
    .other_give(other_give), .other_flag(other_flag), .bus(bus));
  initial forever #2 clk = ~clk;
  task chk(input [7:0] got, input [7:0] exp, input string what);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task summarize;
  begin
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task cmd(input [1:0] c, input [12:0] a, input [7:0] d);
    integer n;
  begin
    @(posedge clk);
    req <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    #1;
    chk({7'h00, busy}, 8'h01, "busy");
    n = 0;
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    chk({7'h00, done}, 8'h01, "done");
    chk({7'h00, busy}, 8'h00, "busy");
    chk(n[7:0], c[1] ? 8'h18 : 8'h0c, "cycles");
  end
  endtask
  task t_reset;
  begin
    #1;
    chk({1'b0, busy, done, sel_n, flag_n, wr_n, oe_n, d_oe}, 8'h1e, "reset pins");
    chk(rdata, 8'h00, "reset rdata");
    chk({7'h00, flag_won}, 8'h00, "reset flag_won");
    $display("t_reset done");
  end
  endtask
  task other(input [2:0] f, input t);
  begin
    @(posedge clk);
    other_flag <= f;
    other_take <= t;
    other_give <= !t;
    @(posedge clk);
    other_take <= 1'b0;
    other_give <= 1'b0;
  end
  endtask
  task t_array;
  begin
    cmd(`DPC_CMD_WRITE, 13'h1fff, 8'ha5);
    cmd(`DPC_CMD_WRITE, 13'h0000, 8'h5a);
    cmd(`DPC_CMD_READ, 13'h1fff, 8'h00);
    chk(rdata, 8'ha5, "rdata");
    cmd(`DPC_CMD_READ, 13'h0000, 8'h00);
    chk(rdata, 8'h5a, "rdata");
    $display("t_array done");
  end
  endtask
  task t_flag;
  begin
    cmd(`DPC_CMD_TAKE, 13'h0003, 8'h00);
    chk(rdata, 8'h00, "rdata");
    chk({7'h00, flag_won}, 8'h01, "flag_won");
    cmd(`DPC_CMD_GIVE, 13'h0003, 8'h00);
    chk(rdata, 8'hff, "rdata");
    chk({7'h00, flag_won}, 8'h00, "flag_won");
    $display("t_flag done");
  end
  endtask
  task t_held;
  begin
    other(3'h5, 1'b1);
    cmd(`DPC_CMD_TAKE, 13'h0005, 8'h00);
    chk(rdata, 8'hff, "rdata");
    chk({7'h00, flag_won}, 8'h00, "flag_won");
    other(3'h5, 1'b0);
    cmd(`DPC_CMD_TAKE, 13'h0005, 8'h00);
    chk({7'h00, flag_won}, 8'h01, "flag_won");
    $display("t_held done");
  end
  endtask
  initial
  begin
    #20000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial
  begin
    repeat (11) @(posedge clk);
    t_reset;
    @(posedge clk);
    reset_n <= 1'b1;
    t_array;
    t_flag;
    t_held;
    summarize;
  end
endmodule
